/* File: logic/msd_top.sv */
// Memory space decoder: program/data address decode and access logic
`timescale 1ns/1ps

// Operation
// - Program addresses 24 bits, from counter or table
// - User space to 7FFFFF; page bit7 for config
// - Program word: even lower, odd upper word
// - PC word aligned, steps by two
// - Reset fetch at zero; vectors below 000200h
// - Primary and alternate vector tables decoded
// - Data EEPROM at 7FFE00, table access only
// - Eight config words at F80000 to F8000E
// - 16-bit byte addresses, separate read/write generators
// - Address bit 15 selects program window
// - RAM implemented; other reads return zero
// - Low byte even, high byte odd
// - Post-modify adds one byte, two word
// - Byte read selected by bit0 onto low lane
// - Shared decode, per-lane write strobes
// - Odd word access traps; write suppressed
// - Byte load keeps register high byte
// - Sign extend and clear upper byte
// - Direct 13-bit near field; 16-bit move
// - Core control bit 2 gates window
// - Register region 0000h-07FFh, unused read zero
module msd_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // Program counter control
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_value,
  output logic [22:0] program_counter,
  // Table operations
  input wire logic table_read_op,
  input wire logic table_write_op,
  input wire logic [7:0] table_page_register,
  input wire logic [15:0] table_offset,
  input wire logic table_upper_word,
  // Program space bus
  output logic [23:0] prog_addr,
  output logic prog_access_ok,
  output logic prog_read_zero,
  output logic prog_in_vectors,
  output logic prog_in_primary_table,
  output logic prog_in_alt_table,
  output logic prog_in_eeprom,
  output logic prog_eeprom_write,
  output logic [7:0] prog_eeprom_index,
  output logic prog_in_config,
  output logic [2:0] prog_config_index,
  output logic prog_in_device_id,
  // Window mapping
  input wire logic [15:0] core_control_register,
  input wire logic [7:0] window_page,
  // Read address generator
  input wire logic rd_valid,
  input wire logic rd_byte,
  input wire logic [1:0] rd_mode,
  input wire logic [15:0] rd_ptr,
  input wire logic [12:0] rd_near_field,
  input wire logic [15:0] rd_move_field,
  output logic [15:0] rd_ptr_next,
  // Write address generator
  input wire msd_pkg::msd_data_req_t wr_req,
  output logic [15:0] wr_ptr_next,
  input wire logic [15:0] wr_ptr,
  // Peripheral register and window data
  input wire logic [15:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic [15:0] window_rdata,
  output logic sfr_wr_lo,
  output logic sfr_wr_hi,
  output logic [15:0] sfr_wdata,
  output logic [15:0] sfr_addr,
  output logic window_req,
  output logic [23:0] window_addr,
  // Read results
  output logic [15:0] rd_data,
  output logic rd_data_valid,
  output logic address_fault,
  // Working register byte handling
  input wire msd_pkg::msd_wreg_req_t wreg_req,
  input wire logic [15:0] wreg_current,
  output logic [15:0] wreg_result
);

  localparam logic [1:0] MODE_INDIRECT = 2'b00;
  localparam logic [1:0] MODE_NEAR = 2'b01;
  localparam logic [1:0] MODE_MOVE = 2'b10;

  logic [15:0] rd_ea;
  logic rd_misaligned;
  logic wr_misaligned;
  msd_pkg::msd_tgt_t rd_tgt;
  msd_pkg::msd_tgt_t wr_tgt;
  logic window_on;
  logic rd_sel_hi;
  msd_pkg::msd_tgt_t rd_tgt_q;
  logic rd_byte_q;
  logic [15:0] ram_rdata;
  logic ram_wr_lo;
  logic ram_wr_hi;
  logic [15:0] wr_lane_data;
  logic [15:0] rd_offset;
  logic [15:0] wr_offset;
  logic [23:0] next_prog_addr;
  logic [15:0] sfr_word_q;
  logic sfr_hit_q;

  // ----------------------------------------
  // Program counter
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      program_counter <= msd_pkg::PROG_RESET_ADDR[22:0];
    end else if (ce) begin
      if (pc_load) begin
        program_counter <= {pc_load_value[22:1], 1'b0};
      end else if (pc_advance) begin
        program_counter <= program_counter + msd_pkg::PC_STEP;
      end
    end
  end

  // ----------------------------------------
  // Program address decode
  // ----------------------------------------
  always_comb begin
    if (table_read_op || table_write_op) begin
      next_prog_addr = {table_page_register, table_offset[15:1], table_upper_word};
    end else begin
      next_prog_addr = {1'b0, program_counter};
    end
  end

  // Config space needs the page bit; user space is the lower half
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prog_addr <= 24'h000000;
      prog_access_ok <= 1'b0;
      prog_read_zero <= 1'b0;
      prog_in_vectors <= 1'b0;
      prog_in_primary_table <= 1'b0;
      prog_in_alt_table <= 1'b0;
      prog_in_eeprom <= 1'b0;
      prog_eeprom_write <= 1'b0;
      prog_eeprom_index <= 8'h00;
      prog_in_config <= 1'b0;
      prog_config_index <= 3'h0;
      prog_in_device_id <= 1'b0;
    end else if (ce) begin
      prog_addr <= next_prog_addr;
      prog_access_ok <= (next_prog_addr <= msd_pkg::USER_SPACE_HI) ||
        ((table_read_op || table_write_op) && table_page_register[msd_pkg::TABLE_PAGE_CFG_BIT]);
      prog_read_zero <= (next_prog_addr > msd_pkg::FLASH_END_DEFAULT) &&
        (next_prog_addr < msd_pkg::EEPROM_BASE);
      prog_in_vectors <= next_prog_addr < msd_pkg::PROG_VECTOR_END;
      prog_in_primary_table <= (next_prog_addr >= msd_pkg::PRIMARY_TABLE_LO) &&
        (next_prog_addr <= msd_pkg::PRIMARY_TABLE_HI);
      prog_in_alt_table <= (next_prog_addr >= msd_pkg::ALT_TABLE_LO) &&
        (next_prog_addr <= msd_pkg::ALT_TABLE_HI);
      prog_in_eeprom <= (table_read_op || table_write_op) && (next_prog_addr >= msd_pkg::EEPROM_BASE) &&
        (next_prog_addr <= msd_pkg::USER_SPACE_HI);
      prog_eeprom_write <= table_write_op && (next_prog_addr >= msd_pkg::EEPROM_BASE) &&
        (next_prog_addr <= msd_pkg::USER_SPACE_HI);
      prog_eeprom_index <= next_prog_addr[8:1];
      prog_in_config <= (table_read_op || table_write_op) &&
        table_page_register[msd_pkg::TABLE_PAGE_CFG_BIT] &&
        (next_prog_addr >= msd_pkg::CONFIG_BASE) && (next_prog_addr <= msd_pkg::CONFIG_LAST) &&
        !next_prog_addr[0];
      prog_config_index <= next_prog_addr[3:1];
      prog_in_device_id <= (table_read_op || table_write_op) &&
        table_page_register[msd_pkg::TABLE_PAGE_CFG_BIT] && (next_prog_addr[23:16] == 8'hFF);
    end
  end

  // ----------------------------------------
  // Effective address generation
  // ----------------------------------------
  always_comb begin
    case (rd_mode)
      MODE_NEAR: rd_ea = {3'b000, rd_near_field};
      MODE_MOVE: rd_ea = rd_move_field;
      MODE_INDIRECT: rd_ea = rd_ptr;
      default: rd_ea = rd_ptr;
    endcase
  end

  assign rd_offset = rd_byte ? msd_pkg::STEP_BYTE : msd_pkg::STEP_WORD;
  assign wr_offset = wr_req.byte_op ? msd_pkg::STEP_BYTE : msd_pkg::STEP_WORD;
  assign rd_ptr_next = rd_ptr + rd_offset;
  assign wr_ptr_next = wr_ptr + wr_offset;

  // ----------------------------------------
  // Data space decode
  // ----------------------------------------
  function automatic msd_pkg::msd_tgt_t decode(input logic [15:0] ea, input logic win);
    if (ea[msd_pkg::EA_WINDOW_BIT]) begin
      decode = win ? msd_pkg::MSD_TGT_WINDOW : msd_pkg::MSD_TGT_ZERO;
    end else if (ea <= msd_pkg::SFR_HI) begin
      decode = msd_pkg::MSD_TGT_SFR;
    end else if (ea < msd_pkg::RAM_BASE + 16'(2 * msd_pkg::RAM_WORDS)) begin
      decode = msd_pkg::MSD_TGT_RAM;
    end else begin
      decode = msd_pkg::MSD_TGT_ZERO;
    end
  endfunction

  assign window_on = core_control_register[msd_pkg::CORE_CTRL_WINDOW_BIT];
  assign rd_tgt = decode(rd_ea, window_on);
  assign wr_tgt = decode(wr_req.effective_address, window_on);
  assign rd_misaligned = rd_valid && !rd_byte && rd_ea[0];
  assign wr_misaligned = wr_req.valid && !wr_req.byte_op && wr_req.effective_address[0];

  // Byte write data is replicated so either lane can take it
  assign wr_lane_data = wr_req.byte_op ? {wr_req.wdata[7:0], wr_req.wdata[7:0]} : wr_req.wdata;
  assign ram_wr_lo = ce && wr_req.valid && !wr_misaligned && (wr_tgt == msd_pkg::MSD_TGT_RAM) &&
    (!wr_req.byte_op || !wr_req.effective_address[0]);
  assign ram_wr_hi = ce && wr_req.valid && !wr_misaligned && (wr_tgt == msd_pkg::MSD_TGT_RAM) &&
    (!wr_req.byte_op || wr_req.effective_address[0]);
  assign sfr_wr_lo = ce && wr_req.valid && !wr_misaligned && (wr_tgt == msd_pkg::MSD_TGT_SFR) &&
    (!wr_req.byte_op || !wr_req.effective_address[0]);
  assign sfr_wr_hi = ce && wr_req.valid && !wr_misaligned && (wr_tgt == msd_pkg::MSD_TGT_SFR) &&
    (!wr_req.byte_op || wr_req.effective_address[0]);
  assign sfr_wdata = wr_lane_data;
  assign sfr_addr = (wr_req.valid ? wr_req.effective_address : rd_ea) & ~16'h0001;
  assign window_req = rd_valid && (rd_tgt == msd_pkg::MSD_TGT_WINDOW);
  assign window_addr = {window_page, 1'b0, rd_ea[14:1], 1'b0};

  // Fault flagged in the cycle its write is blocked; read still completes
  assign address_fault = ce && (rd_misaligned || wr_misaligned);

  msd_ram u_ram (
    .mclk(mclk),
    .ce(ce),
    .rd_en(rd_valid && (rd_tgt == msd_pkg::MSD_TGT_RAM)),
    .rd_addr(rd_ea[msd_pkg::RAM_AW:1] - msd_pkg::RAM_BASE[msd_pkg::RAM_AW:1]),
    .rd_data(ram_rdata),
    .wr_addr(wr_req.effective_address[msd_pkg::RAM_AW:1] - msd_pkg::RAM_BASE[msd_pkg::RAM_AW:1]),
    .wr_lo(ram_wr_lo),
    .wr_hi(ram_wr_hi),
    .wr_data(wr_lane_data)
  );

  // ----------------------------------------
  // Read return path
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_tgt_q <= msd_pkg::MSD_TGT_NONE;
      rd_byte_q <= 1'b0;
      rd_sel_hi <= 1'b0;
      rd_data_valid <= 1'b0;
    end else if (ce) begin
      rd_tgt_q <= rd_valid ? rd_tgt : msd_pkg::MSD_TGT_NONE;
      rd_byte_q <= rd_byte;
      rd_sel_hi <= rd_ea[0];
      rd_data_valid <= rd_valid;
    end
  end

  // Register data captured at the request edge; address may move after
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_word_q <= 16'h0000;
      sfr_hit_q <= 1'b0;
    end else if (ce) begin
      sfr_word_q <= sfr_rdata;
      sfr_hit_q <= sfr_hit;
    end
  end

  // Window data arrives one cycle after the request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= 16'h0000;
      case (rd_tgt_q)
        msd_pkg::MSD_TGT_RAM: begin
          rd_data <= rd_byte_q ? {8'h00, (rd_sel_hi ? ram_rdata[15:8] : ram_rdata[7:0])} : ram_rdata;
        end
        msd_pkg::MSD_TGT_SFR: begin
          if (sfr_hit_q) begin
            rd_data <= rd_byte_q ? {8'h00, (rd_sel_hi ? sfr_word_q[15:8] : sfr_word_q[7:0])} : sfr_word_q;
          end
        end
        msd_pkg::MSD_TGT_WINDOW: begin
          rd_data <= rd_byte_q ? {8'h00, (rd_sel_hi ? window_rdata[15:8] : window_rdata[7:0])} : window_rdata;
        end
        default: begin
          rd_data <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Working register byte handling
  // ----------------------------------------
  always_comb begin
    if (wreg_req.sign_extend_op) begin
      wreg_result = {{8{wreg_current[7]}}, wreg_current[7:0]};
    end else if (wreg_req.clear_upper_byte_op) begin
      wreg_result = {8'h00, wreg_current[7:0]};
    end else if (wreg_req.load_byte) begin
      wreg_result = {wreg_current[15:8], wreg_req.data[7:0]};
    end else begin
      wreg_result = wreg_req.data;
    end
  end

endmodule

/* File: logic/msd_pkg.sv */
// Package: constants and carriers for the memory space decoder
package msd_pkg;

  // ----------------------------------------
  // Program space
  // ----------------------------------------
  localparam logic [23:0] PROG_RESET_ADDR = 24'h000000;
  localparam logic [23:0] PROG_RESET_TARGET = 24'h000002;
  localparam logic [23:0] PROG_VECTOR_END = 24'h000200;
  localparam logic [23:0] PRIMARY_TABLE_LO = 24'h000004;
  localparam logic [23:0] PRIMARY_TABLE_HI = 24'h0000FF;
  localparam logic [23:0] ALT_TABLE_LO = 24'h000104;
  localparam logic [23:0] ALT_TABLE_HI = 24'h0001FF;
  localparam logic [23:0] USER_SPACE_HI = 24'h7FFFFF;
  localparam logic [23:0] EEPROM_BASE = 24'h7FFE00;
  localparam logic [23:0] CONFIG_BASE = 24'hF80000;
  localparam logic [23:0] CONFIG_LAST = 24'hF8000E;
  localparam logic [23:0] FLASH_END_DEFAULT = 24'h002BFE;
  localparam logic [22:0] PC_STEP = 23'h000002;
  localparam int TABLE_PAGE_CFG_BIT = 7;
  localparam int EEPROM_WORDS = 256;
  localparam int CONFIG_WORDS = 7;

  // ----------------------------------------
  // Data space
  // ----------------------------------------
  localparam int EA_WINDOW_BIT = 15;
  localparam int CORE_CTRL_WINDOW_BIT = 2;
  localparam logic [15:0] SFR_HI = 16'h07FF;
  localparam logic [15:0] NEAR_HI = 16'h1FFF;
  localparam logic [15:0] RAM_BASE = 16'h0800;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_AW = 10;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  // Decode targets
  typedef enum logic [2:0] {
    MSD_TGT_NONE = 3'b000,
    MSD_TGT_SFR = 3'b001,
    MSD_TGT_RAM = 3'b010,
    MSD_TGT_WINDOW = 3'b011,
    MSD_TGT_ZERO = 3'b100
  } msd_tgt_t;

  // Working register update request
  typedef struct packed {
    logic load_byte;
    logic sign_extend_op;
    logic clear_upper_byte_op;
    logic [15:0] data;
  } msd_wreg_req_t;

  // Data access request from an address generator
  typedef struct packed {
    logic valid;
    logic byte_op;
    logic [15:0] effective_address;
    logic [15:0] wdata;
  } msd_data_req_t;

endpackage

/* File: logic/msd_ram.sv */
// Data RAM with two byte lanes and a registered read port
`timescale 1ns/1ps
module msd_ram (
  // Clock and clock enable
  input wire logic mclk,
  input wire logic ce,
  // Read port
  input wire logic rd_en,
  input wire logic [msd_pkg::RAM_AW-1:0] rd_addr,
  output logic [15:0] rd_data,
  // Write port with lane strobes
  input wire logic [msd_pkg::RAM_AW-1:0] wr_addr,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [15:0] wr_data
);

  logic [7:0] lane_lo [msd_pkg::RAM_WORDS];
  logic [7:0] lane_hi [msd_pkg::RAM_WORDS];

  // ----------------------------------------
  // Lanes share a decode, write separately
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (ce && wr_lo) begin
      lane_lo[wr_addr] <= wr_data[7:0];
    end
    if (ce && wr_hi) begin
      lane_hi[wr_addr] <= wr_data[15:8];
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && rd_en) begin
      rd_data <= {lane_hi[rd_addr], lane_lo[rd_addr]};
    end
  end

endmodule

/* File: verif/msd_top_sva.sv */
// Checker: port assertions for the decoder top
`timescale 1ns/1ps
module msd_top_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // Program side
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [22:0] program_counter,
  input wire logic [23:0] prog_addr,
  input wire logic prog_access_ok,
  input wire logic prog_in_eeprom,
  input wire logic [7:0] prog_eeprom_index,
  // Data side
  input wire logic [15:0] core_control_register,
  input wire logic rd_valid,
  input wire msd_pkg::msd_data_req_t wr_req,
  input wire logic sfr_wr_lo,
  input wire logic sfr_wr_hi,
  input wire logic window_req,
  input wire logic rd_data_valid,
  input wire logic address_fault,
  // Working register
  input wire msd_pkg::msd_wreg_req_t wreg_req,
  input wire logic [15:0] wreg_current,
  input wire logic [15:0] wreg_result
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_pc_step;
    ce && pc_advance && !pc_load |=> program_counter == $past(program_counter) + 23'h000002;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step by two");
  property p_odd_write;
    ce && wr_req.valid && !wr_req.byte_op && wr_req.effective_address[0] |-> address_fault && !sfr_wr_lo && !sfr_wr_hi;
  endproperty
  a_odd_write: assert property (p_odd_write) else $error("odd word write not trapped");
  property p_byte_lane;
    ce && wr_req.valid && wr_req.byte_op && wr_req.effective_address <= 16'h07FF
      |-> sfr_wr_hi == wr_req.effective_address[0] && sfr_wr_lo == !wr_req.effective_address[0];
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte write hit wrong lane");
  property p_rd_answer;
    ce && rd_valid |=> rd_data_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_cause;
    rd_data_valid |-> $past(ce && rd_valid);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without request");
  property p_window_gate;
    !core_control_register[2] |-> !window_req;
  endproperty
  a_window_gate: assert property (p_window_gate) else $error("window used while disabled");
  property p_user_ok;
    $past(rst_b) && !prog_addr[23] |-> prog_access_ok;
  endproperty
  a_user_ok: assert property (p_user_ok) else $error("user program access refused");
  property p_eeprom_index;
    prog_in_eeprom |-> prog_eeprom_index == prog_addr[8:1] && prog_addr[23:9] == 15'h3FFF;
  endproperty
  a_eeprom_index: assert property (p_eeprom_index) else $error("eeprom decode wrong");
  property p_byte_load;
    wreg_req.load_byte && !wreg_req.sign_extend_op && !wreg_req.clear_upper_byte_op
      |-> wreg_result == {wreg_current[15:8], wreg_req.data[7:0]};
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load touched high byte");
endmodule

bind msd_top msd_top_sva u_sva (
  .mclk, .rst_b, .ce, .pc_advance, .pc_load, .program_counter, .prog_addr, .prog_access_ok, .prog_in_eeprom,
  .prog_eeprom_index, .core_control_register, .rd_valid, .wr_req, .sfr_wr_lo, .sfr_wr_hi, .window_req,
  .rd_data_valid, .address_fault, .wreg_req, .wreg_current, .wreg_result
);

/* File: verif/msd_periph_model.sv */
// Partner model: register file and program window responder
`timescale 1ns/1ps
module msd_periph_model (
  // Clock
  input wire logic mclk,
  // Register side
  input wire logic [15:0] sfr_addr,
  output logic sfr_hit,
  output logic [15:0] sfr_rdata,
  // Window side
  input wire logic window_req,
  input wire logic [23:0] window_addr,
  output logic [15:0] window_rdata
);
  logic [15:0] noise = 16'h0000;
  // Only one word answers; elsewhere the bus shows moving junk
  assign sfr_hit = (sfr_addr == 16'h0044);
  assign sfr_rdata = sfr_hit ? 16'h0004 : noise;
  always_ff @(posedge mclk) begin
    noise <= noise + 16'h1357;
    // Released bus inverts rather than holding its value
    window_rdata <= window_req ? (window_addr[15:0] ^ 16'h5A5A) : ~window_rdata;
  end
endmodule

/* File: verif/msd_top_tb_top.sv */
// Testbench: directed scenarios for the decoder top
`timescale 1ns/1ps
module msd_top_tb_top;
  logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, pc_advance = 1'b0, pc_load = 1'b0, table_read_op = 1'b0;
  logic table_write_op = 1'b0, table_upper_word = 1'b0, rd_valid = 1'b0, rd_byte = 1'b0, sfr_hit, window_req;
  logic [22:0] pc_load_value = 23'h000000, program_counter;
  logic [23:0] prog_addr, window_addr;
  logic [7:0] table_page_register = 8'h00, window_page = 8'h12;
  logic [15:0] table_offset = 16'h0000, core_control_register = 16'h0000, rd_ptr = 16'h0000;
  logic [15:0] rd_move_field = 16'h0000, wr_ptr = 16'h0000, wreg_current = 16'h0000, rd_ptr_next, wr_ptr_next;
  logic [15:0] sfr_rdata, window_rdata, sfr_wdata, sfr_addr, rd_data, wreg_result;
  logic [12:0] rd_near_field = 13'h0000;
  logic [1:0] rd_mode = 2'h0;
  logic [6:0] flags;
  logic p_eew, p_dev;
  logic [7:0] p_eidx;
  logic [2:0] p_cidx;
  logic p_ok, p_zero, p_vec, p_pri, p_alt, p_ee, p_cfg, sfr_wr_lo, sfr_wr_hi, rd_data_valid, address_fault;
  msd_pkg::msd_data_req_t wr_req = '0;
  msd_pkg::msd_wreg_req_t wreg_req = '0;
  int n_errors = 0, checked = 0;
  assign flags = {p_ok, p_zero, p_vec, p_pri, p_alt, p_ee, p_cfg};
  msd_top uut (
    .mclk, .rst_b, .ce, .pc_advance, .pc_load, .pc_load_value, .program_counter, .table_read_op, .table_write_op,
    .table_page_register, .table_offset, .table_upper_word, .prog_addr, .prog_access_ok(p_ok),
    .prog_read_zero(p_zero), .prog_in_vectors(p_vec), .prog_in_primary_table(p_pri), .prog_in_alt_table(p_alt),
    .prog_in_eeprom(p_ee), .prog_eeprom_write(p_eew), .prog_eeprom_index(p_eidx), .prog_in_config(p_cfg),
    .prog_config_index(p_cidx), .prog_in_device_id(p_dev), .core_control_register, .window_page,
    .rd_valid, .rd_byte,
    .rd_mode, .rd_ptr, .rd_near_field, .rd_move_field, .rd_ptr_next, .wr_req, .wr_ptr_next, .wr_ptr, .sfr_rdata,
    .sfr_hit, .window_rdata, .sfr_wr_lo, .sfr_wr_hi, .sfr_wdata, .sfr_addr, .window_req, .window_addr, .rd_data,
    .rd_data_valid, .address_fault, .wreg_req, .wreg_current, .wreg_result
  );
  msd_periph_model u_periph (.mclk, .sfr_addr, .sfr_hit, .sfr_rdata, .window_req, .window_addr, .window_rdata);
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic b, input logic [15:0] a, d, input logic [2:0] exp);
    @(posedge mclk);
    wr_req <= {1'b1, b, a, d};
    wr_ptr <= a;
    #1;
    check("fault_strobes", {address_fault, sfr_wr_hi, sfr_wr_lo}, exp);
    check("wr_ptr_next", wr_ptr_next, a + (b ? 16'h0001 : 16'h0002));
    check("sfr_addr", sfr_addr, {a[15:1], 1'b0});
    if (exp[1:0] != 2'b00) check("sfr_wdata", sfr_wdata, b ? {d[7:0], d[7:0]} : d);
    @(posedge mclk);
    wr_req <= '0;
  endtask
  task automatic rd(input logic [1:0] m, input logic b, input logic [15:0] a, exp);
    @(posedge mclk);
    rd_valid <= 1'b1;
    rd_byte <= b;
    rd_mode <= m;
    rd_ptr <= (m == 2'h0 || m == 2'h3) ? a : ~a;
    rd_near_field <= (m == 2'h1) ? a[12:0] : ~a[12:0];
    rd_move_field <= (m == 2'h2) ? a : ~a;
    #1;
    check("rd_fault", address_fault, !b && a[0]);
    check("rd_ptr_next", rd_ptr_next, rd_ptr + (b ? 16'h0001 : 16'h0002));
    if (a[15]) check("window_req", window_req, core_control_register[2]);
    if (a[15] && core_control_register[2]) check("window_addr", window_addr, {window_page, 1'b0, a[14:1], 1'b0});
    @(posedge mclk);
    rd_valid <= 1'b0;
    #1 check("rd_data_valid", rd_data_valid, 1'b1);
    @(posedge mclk);
    // Faulting word read still completes, but its data is undefined
    #1 if (b || !a[0]) check("rd_data", rd_data, exp);
  endtask
  task automatic wreg(input logic [2:0] op, input logic [15:0] d, cur, exp);
    @(posedge mclk);
    wreg_req <= {op, d};
    wreg_current <= cur;
    #1 check("wreg_result", wreg_result, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_prog;
    logic [23:0] ta [7] = '{24'h000008, 24'h000100, 24'h000104, 24'h000200, 24'h003000, 24'h7FFE02, 24'hF80006};
    logic [6:0] tf [7] = '{7'h58, 7'h50, 7'h54, 7'h40, 7'h60, 7'h42, 7'h41};
    #1 check("program_counter", program_counter, 24'h000000);
    @(posedge mclk);
    pc_advance <= 1'b1;
    #1 check("reset_fetch", {prog_addr[23:7], flags}, 24'h000050);
    repeat (3) @(posedge mclk);
    pc_load <= 1'b1;
    pc_load_value <= 23'h0001F0;
    #1 check("program_counter", program_counter, 24'h000006);
    @(posedge mclk);
    pc_load <= 1'b0;
    pc_advance <= 1'b0;
    #1 check("program_counter", program_counter, 24'h0001F0);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      table_read_op <= 1'b1;
      {table_page_register, table_offset} <= ta[i];
      @(posedge mclk);
      #1 check("prog_flags", flags, tf[i]);
      check("prog_addr", prog_addr, ta[i]);
      check("prog_index", {p_cidx, p_eidx}, {ta[i][3:1], ta[i][8:1]});
    end
    @(posedge mclk);
    table_read_op <= 1'b0;
    table_write_op <= 1'b1;
    table_upper_word <= 1'b1;
    {table_page_register, table_offset} <= 24'h7FFE10;
    @(posedge mclk);
    table_page_register <= 8'hFF;
    #1 check("prog_addr", prog_addr, 24'h7FFE11);
    check("eeprom_write", {p_eew, p_dev}, 2'b10);
    @(posedge mclk);
    table_write_op <= 1'b0;
    table_upper_word <= 1'b0;
    ce <= 1'b0;
    pc_advance <= 1'b1;
    #1 check("device_id", {p_eew, p_dev}, 2'b01);
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    pc_advance <= 1'b0;
    #1 check("frozen_pc", program_counter, 24'h0001F0);
    check("frozen_id", p_dev, 1'b1);
    $display("test prog done");
  endtask
  task automatic t_data;
    wr(1'b0, 16'h0044, 16'h1234, 3'h3);
    wr(1'b1, 16'h0045, 16'h00CD, 3'h2);
    wr(1'b0, 16'h0045, 16'h1234, 3'h4);
    wr(1'b1, 16'h0044, 16'h00EF, 3'h1);
    wr(1'b0, 16'h0800, 16'hA55A, 3'h0);
    wr(1'b1, 16'h0800, 16'h003C, 3'h0);
    rd(2'h0, 1'b0, 16'h0800, 16'hA53C);
    rd(2'h0, 1'b1, 16'h0801, 16'h00A5);
    rd(2'h1, 1'b1, 16'h0800, 16'h003C);
    rd(2'h2, 1'b0, 16'h2000, 16'h0000);
    rd(2'h0, 1'b0, 16'h0801, 16'h0000);
    rd(2'h0, 1'b0, 16'h0044, 16'h0004);
    rd(2'h0, 1'b0, 16'h0046, 16'h0000);
    rd(2'h3, 1'b0, 16'h8004, 16'h0000);
    @(posedge mclk);
    core_control_register <= 16'h0004;
    rd(2'h0, 1'b0, 16'h8004, 16'h5A5E);
    $display("test data done");
  endtask
  task automatic t_wreg;
    wreg(3'h4, 16'h12AB, 16'h5500, 16'h55AB);
    wreg(3'h2, 16'h0080, 16'h0080, 16'hFF80);
    wreg(3'h1, 16'hAB12, 16'hAB12, 16'h0012);
    $display("test wreg done");
  endtask
  initial begin
    forever #4 mclk = ~mclk;
  end
  initial begin
    // Cut a hang well past the fewer than one hundred cycles the tests need
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_prog();
    t_data();
    t_wreg();
    stop_test();
  end
endmodule
